// ---- verilog/gpl_params.svh ----
`ifndef GPL_PARAMS_SVH
`define GPL_PARAMS_SVH

// Register indices; byte address is four times the index
`define GPL_IDX_SINK_EN    14'h0f82
`define GPL_IDX_SINK_HI    14'h0f83
`define GPL_IDX_SINK_LO    14'h0f84
`define GPL_IDX_DIR        14'h0fd0
`define GPL_IDX_ALT        14'h0fd1
`define GPL_IDX_ODRAIN     14'h0fd2
`define GPL_IDX_OUT        14'h0fd3
`define GPL_IDX_IN         14'h0fd4
`define GPL_IDX_WAKE_EN    14'h0fd5
`define GPL_IDX_PIN_IRQ_EN 14'h0fd6
`define GPL_IDX_CAUSE      14'h0ff0
`define GPL_IDX_CTRL       14'h0ff1
`define GPL_IDX_STAT       14'h0ff2
`define GPL_IDX_MASK       14'h0ff3

// Reset values
`define GPL_RST_OUT        8'h00
`define GPL_RST_SINK_EN    8'h00
`define GPL_RST_SINK_LO    8'h00
`define GPL_RST_SINK_HI    8'h00
`define GPL_RST_CFG        8'h00
`define GPL_RST_CAUSE      2'h0
`define GPL_RST_STAT       3'h0

// Field positions
`define GPL_CAUSE_HALT     0
`define GPL_CAUSE_WDT      1
`define GPL_STAT_WAKE      0
`define GPL_STAT_WDT       1
`define GPL_STAT_PIN       2
`define GPL_CTRL_WDT_IRQ   0

// Recovery delay: time in ns, clock period in ns, cycles rounded up
`define GPL_RECOVERY_NS    6400
`define GPL_CLK_PERIOD_NS  100
`define GPL_RECOVERY_CYC   ((`GPL_RECOVERY_NS + `GPL_CLK_PERIOD_NS - 1) / `GPL_CLK_PERIOD_NS)

`endif

// ---- verilog/gpl_pkg.sv ----
package gpl_pkg;

  typedef enum logic [1:0]
  {
    GPL_RUN     = 2'b00,
    GPL_HALT    = 2'b01,
    GPL_RECOVER = 2'b10
  } gpl_state_type;

  typedef struct packed
  {
    logic [7:0]  out;
    logic [7:0]  oe;
    logic [7:0]  sink_en;
    logic [15:0] sink_code;
  } gpl_pad_type;

endpackage

// ---- verilog/gpl_wake_sync.sv ----
`timescale 1ns/100ps

module gpl_wake_sync
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] pin_in,
  input  wire logic [7:0] wake_en,
  output logic      [7:0] pin_sync,
  output logic      [7:0] change
);

  logic [7:0] meta_q;
  logic [7:0] sync_q;
  logic [7:0] prev_q;

  // Two-stage synchroniser plus previous level for change detect
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= 8'h00;
      sync_q <= 8'h00;
      prev_q <= 8'h00;
    end
    else
    begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Either direction counts; only enabled pins report
  assign pin_sync = sync_q;
  assign change   = (sync_q ^ prev_q) & wake_en;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Start only once out of reset, else the reset zeros meet live pins
  chk_sync_two_stage: assert property (presetn |-> ##2 pin_sync == $past(pin_in, 2))
    else $error("wake pin synchroniser delay wrong");

endmodule

// ---- verilog/gpl_port.sv ----
// Our own choice: register access over APB.
`timescale 1ns/100ps
`include "gpl_params.svh"

module gpl_port
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [15:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [7:0]           pin_in,
  input  wire logic [7:0]           alt_out,
  input  wire logic [7:0]           alt_oe,
  input  wire logic                 halt_req,
  input  wire logic                 wdt_timeout,
  output gpl_pkg::gpl_pad_type      pad,
  output logic                      halted,
  output logic                      irq
);

  localparam int CHK_REC_MAX = 70;

  function automatic logic hit(input logic [15:0] addr, input logic [13:0] idx);
    hit = (addr == {idx, 2'b00});
  endfunction

  gpl_pkg::gpl_state_type state_q;
  gpl_pkg::gpl_state_type state_d;
  gpl_pkg::gpl_pad_type   pad_q;
  gpl_pkg::gpl_pad_type   pad_d;

  logic [7:0]  out_q;
  logic [7:0]  sink_en_q;
  logic [7:0]  sink_lo_q;
  logic [7:0]  sink_hi_q;
  logic [7:0]  dir_q;
  logic [7:0]  alt_q;
  logic [7:0]  odrain_q;
  logic [7:0]  sample_q;
  logic [7:0]  wake_en_q;
  logic [7:0]  pin_irq_en_q;
  logic [7:0]  ctrl_q;
  logic [2:0]  stat_q;
  logic [2:0]  mask_q;
  logic [1:0]  cause_q;
  logic        wdt_pend_q;
  logic [7:0]  rec_cnt_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        halted_q;
  logic        irq_q;
  logic [7:0]  pin_sync;
  logic [7:0]  wake_change;

  gpl_wake_sync u_wake_sync
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin_in   (pin_in),
    .wake_en  (wake_en_q),
    .pin_sync (pin_sync),
    .change   (wake_change)
  );

  // Address decode
  wire h_sink_en = hit(paddr, `GPL_IDX_SINK_EN);
  wire h_sink_hi = hit(paddr, `GPL_IDX_SINK_HI);
  wire h_sink_lo = hit(paddr, `GPL_IDX_SINK_LO);
  wire h_dir     = hit(paddr, `GPL_IDX_DIR);
  wire h_alt     = hit(paddr, `GPL_IDX_ALT);
  wire h_odrain  = hit(paddr, `GPL_IDX_ODRAIN);
  wire h_out     = hit(paddr, `GPL_IDX_OUT);
  wire h_in      = hit(paddr, `GPL_IDX_IN);
  wire h_wake    = hit(paddr, `GPL_IDX_WAKE_EN);
  wire h_pin_irq = hit(paddr, `GPL_IDX_PIN_IRQ_EN);
  wire h_cause   = hit(paddr, `GPL_IDX_CAUSE);
  wire h_ctrl    = hit(paddr, `GPL_IDX_CTRL);
  wire h_stat    = hit(paddr, `GPL_IDX_STAT);
  wire h_mask    = hit(paddr, `GPL_IDX_MASK);
  wire mapped    = h_sink_en | h_sink_hi | h_sink_lo | h_dir | h_alt | h_odrain | h_out
                 | h_in | h_wake | h_pin_irq | h_cause | h_ctrl | h_stat | h_mask;

  // Bus phases; one wait-free access cycle after setup
  wire setup  = psel & ~penable & ~pready_q;
  wire wr_en  = psel & penable & pready_q & pwrite & mapped;
  wire [7:0] wb = pwdata[7:0];

  // Read selection, narrow registers in the low bits
  wire [7:0] rd_byte = ({8{h_sink_en}} & sink_en_q) | ({8{h_sink_hi}} & sink_hi_q)
                     | ({8{h_sink_lo}} & sink_lo_q) | ({8{h_dir}} & dir_q)
                     | ({8{h_alt}} & alt_q) | ({8{h_odrain}} & odrain_q)
                     | ({8{h_out}} & out_q) | ({8{h_in}} & sample_q)
                     | ({8{h_wake}} & wake_en_q) | ({8{h_pin_irq}} & pin_irq_en_q)
                     | ({8{h_cause}} & {6'h00, cause_q}) | ({8{h_ctrl}} & ctrl_q)
                     | ({8{h_stat}} & {5'h00, stat_q}) | ({8{h_mask}} & {5'h00, mask_q});

  // Bus answer registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end
    else
    begin
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup)
        prdata_q <= {24'h000000, rd_byte};
    end
  end

  // Software configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_q        <= `GPL_RST_OUT;
      sink_en_q    <= `GPL_RST_SINK_EN;
      sink_lo_q    <= `GPL_RST_SINK_LO;
      sink_hi_q    <= `GPL_RST_SINK_HI;
      dir_q        <= `GPL_RST_CFG;
      alt_q        <= `GPL_RST_CFG;
      odrain_q     <= `GPL_RST_CFG;
      wake_en_q    <= `GPL_RST_CFG;
      pin_irq_en_q <= `GPL_RST_CFG;
      ctrl_q       <= `GPL_RST_CFG;
      mask_q       <= `GPL_RST_STAT;
    end
    else if (wr_en)
    begin
      if (h_out)     out_q        <= wb;
      if (h_sink_en) sink_en_q    <= wb;
      if (h_sink_lo) sink_lo_q    <= wb;
      if (h_sink_hi) sink_hi_q    <= wb;
      if (h_dir)     dir_q        <= wb;
      if (h_alt)     alt_q        <= wb;
      if (h_odrain)  odrain_q     <= wb;
      if (h_wake)    wake_en_q    <= wb;
      if (h_pin_irq) pin_irq_en_q <= wb;
      if (h_ctrl)    ctrl_q       <= wb;
      if (h_mask)    mask_q       <= wb[2:0];
    end
  end

  // Halt and recovery events
  wire in_halt   = (state_q == gpl_pkg::GPL_HALT);
  wire wdt_wake  = in_halt & wdt_timeout;
  wire pin_wake  = in_halt & (|wake_change);
  wire rec_done  = (state_q == gpl_pkg::GPL_RECOVER) & (rec_cnt_q == 8'h01);
  wire wdt_irqm  = ctrl_q[`GPL_CTRL_WDT_IRQ];
  wire run_wdt   = (state_q == gpl_pkg::GPL_RUN) & wdt_timeout;

  // Sampling only while running, or once when recovery ends
  wire       sample_upd = (state_q == gpl_pkg::GPL_RUN) | rec_done;
  wire [7:0] sample_chg = (pin_sync ^ sample_q) & pin_irq_en_q;
  wire       pin_evt    = sample_upd & (|sample_chg);

  // Hardware set terms; a set in the clear cycle wins
  wire [1:0] cause_set;
  assign cause_set[`GPL_CAUSE_HALT] = wdt_wake | pin_wake;
  assign cause_set[`GPL_CAUSE_WDT]  = wdt_wake | run_wdt;
  wire [2:0] stat_set;
  assign stat_set[`GPL_STAT_WAKE] = rec_done;
  assign stat_set[`GPL_STAT_WDT]  = (rec_done & wdt_pend_q) | (run_wdt & wdt_irqm);
  assign stat_set[`GPL_STAT_PIN]  = pin_evt;
  wire [1:0] cause_clr = (wr_en & h_cause) ? wb[1:0] : 2'h0;
  wire [2:0] stat_clr  = (wr_en & h_stat) ? wb[2:0] : 3'h0;

  // State sequencing
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      gpl_pkg::GPL_RUN:
        if (halt_req)
          state_d = gpl_pkg::GPL_HALT;
      gpl_pkg::GPL_HALT:
        if (wdt_wake | pin_wake)
          state_d = gpl_pkg::GPL_RECOVER;
      gpl_pkg::GPL_RECOVER:
        if (rec_done)
          state_d = gpl_pkg::GPL_RUN;
      default:
        state_d = gpl_pkg::GPL_RUN;
    endcase
  end

  // Recovery delay counter and held watchdog request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q    <= gpl_pkg::GPL_RUN;
      rec_cnt_q  <= 8'h00;
      wdt_pend_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (wdt_wake | pin_wake)
        rec_cnt_q <= 8'(`GPL_RECOVERY_CYC);
      else if (rec_cnt_q != 8'h00)
        rec_cnt_q <= rec_cnt_q - 8'h01;
      if (wdt_wake & wdt_irqm)
        wdt_pend_q <= 1'b1;
      else if (rec_done)
        wdt_pend_q <= 1'b0;
    end
  end

  // Sample, flags and interrupt line
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sample_q <= 8'h00;
      cause_q  <= `GPL_RST_CAUSE;
      stat_q   <= `GPL_RST_STAT;
      irq_q    <= 1'b0;
    end
    else
    begin
      if (sample_upd)
        sample_q <= pin_sync;
      cause_q <= (cause_q & ~cause_clr) | cause_set;
      stat_q  <= (stat_q & ~stat_clr) | stat_set;
      irq_q   <= |(stat_q & mask_q);
    end
  end

  // Pad drive; alternate function overrides the latch
  always_comb
  begin
    pad_d.out     = (alt_q & alt_out) | (~alt_q & out_q);
    pad_d.oe      = (alt_q & alt_oe) | (~alt_q & dir_q & ~(odrain_q & out_q));
    pad_d.sink_en = sink_en_q;
    for (int i = 0; i < 8; i++)
      pad_d.sink_code[2*i +: 2] = {sink_hi_q[i], sink_lo_q[i]};
  end

  // Registered outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pad_q    <= '0;
      halted_q <= 1'b0;
    end
    else
    begin
      pad_q    <= pad_d;
      halted_q <= (state_d != gpl_pkg::GPL_RUN);
    end
  end

  assign pad     = pad_q;
  assign halted  = halted_q;
  assign irq     = irq_q;
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_wdt_halt_cause: assert property (wdt_wake |=> cause_q == 2'b11)
    else $error("watchdog wake did not set both cause flags");
  chk_wdt_irq_late: assert property ($rose(stat_q[`GPL_STAT_WDT]) |-> $past(state_q) == gpl_pkg::GPL_RUN || $past(rec_done))
    else $error("watchdog interrupt raised before recovery ended");
  chk_wdt_irq_bound: assert property (wdt_wake & wdt_irqm |-> ##[1:CHK_REC_MAX] stat_q[`GPL_STAT_WDT])
    else $error("watchdog interrupt missing after recovery");
  chk_pin_wake_start: assert property (pin_wake & ~wdt_wake |=> state_q == gpl_pkg::GPL_RECOVER && cause_q[`GPL_CAUSE_HALT])
    else $error("pin change did not start recovery");
  chk_sample_frozen: assert property (state_q != gpl_pkg::GPL_RUN && !rec_done |=> $stable(sample_q))
    else $error("input sample moved while halted");
  chk_sample_at_end: assert property (rec_done |=> sample_q == $past(pin_sync))
    else $error("sample not taken at end of recovery");
  chk_latch_gated: assert property (##1 (pad_q.oe & ~$past(alt_q) & ~$past(dir_q)) == 8'h00)
    else $error("latch driven on input pin");
  chk_odrain_high: assert property (##1 (pad_q.oe & pad_q.out & $past(odrain_q) & ~$past(alt_q)) == 8'h00)
    else $error("open-drain pin driven high");
  chk_sink_write: assert property (wr_en & h_sink_en |-> ##2 pad_q.sink_en == $past(wb, 2))
    else $error("sink enable not mapped to pins");
  chk_sink_code: assert property (##1 pad_q.sink_code[15:14] == {$past(sink_hi_q[7]), $past(sink_lo_q[7])})
    else $error("drive code of pin 7 wrong");

  cov_wdt_wake: cover property (wdt_wake ##[1:CHK_REC_MAX] rec_done);
  cov_pin_wake: cover property (pin_wake ##[1:CHK_REC_MAX] (rec_done & pin_evt));
  cov_short_pulse: cover property (pin_wake ##[1:CHK_REC_MAX] (rec_done & ~pin_evt));
  cov_bus_write: cover property (wr_en & h_out);

endmodule

// ---- sim/gpl_pin_model.sv ----
`timescale 1ns/100ps

// External pins: a source may drive a pin, else the port drives it, else a
// pull-up holds it high; a sinking LED pin reads low
module gpl_pin_model
(
  input  wire gpl_pkg::gpl_pad_type pad,
  input  wire logic [7:0]           ext_drv,
  input  wire logic [7:0]           ext_val,
  output logic      [7:0]           pin_in
);
  // Pull-up also supplies the high level of an open-drain pin
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (ext_drv[i])
        pin_in[i] = ext_val[i];
      else if (pad.oe[i])
        pin_in[i] = pad.out[i];
      else
        pin_in[i] = !pad.sink_en[i];
    end
  end
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/100ps
`include "gpl_params.svh"

module tb_top;
  logic                 pclk;
  logic                 presetn;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [15:0]          paddr;
  logic [31:0]          pwdata;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic [7:0]           pin_in;
  logic [7:0]           alt_out;
  logic [7:0]           alt_oe;
  logic                 halt_req;
  logic                 wdt_timeout;
  logic [7:0]           ext_drv;
  logic [7:0]           ext_val;
  logic                 halted;
  logic                 irq;
  gpl_pkg::gpl_pad_type pad;
  int                   bad_count;
  int                   n_compared;
  int                   cycles = 0;

  gpl_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .alt_out(alt_out), .alt_oe(alt_oe),
    .halt_req(halt_req), .wdt_timeout(wdt_timeout), .pad(pad), .halted(halted), .irq(irq));

  gpl_pin_model pins (.pad(pad), .ext_drv(ext_drv), .ext_val(ext_val), .pin_in(pin_in));

  // Clock, 100 ns period
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Hang guard; the full run needs well under a thousand cycles
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask

  // One APB transfer; the request stands until pready is sampled high
  task automatic apb(input logic wr, input logic [13:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge pclk);
    end
    check("pready", 32'h1, {31'h0, pready});
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [13:0] idx, input logic [7:0] wd);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, idx, wd, rd, err);
  endtask

  task automatic rdc(input logic [13:0] idx, input logic [31:0] exp, input string what);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, idx, 8'h00, rd, err);
    check(what, exp, rd);
  endtask

  // Wait a bounded time for halted to reach a level; returns cycles spent
  task automatic wait_halted(input logic v, input int lim, output int n);
    n = 0;
    while (halted !== v && n < lim)
    begin
      n++;
      @(posedge pclk);
    end
    check("halted", {31'h0, v}, {31'h0, halted});
  endtask

  task automatic enter_halt;
    int n;
    @(posedge pclk);
    halt_req <= 1'b1;
    @(posedge pclk);
    halt_req <= 1'b0;
    wait_halted(1'b1, 5, n);
  endtask

  task automatic t_reset;
    logic [31:0] rd;
    logic        err;
    rdc(`GPL_IDX_SINK_EN, 32'h0, "sink enable at reset");
    rdc(`GPL_IDX_SINK_LO, 32'h0, "sink level low at reset");
    rdc(`GPL_IDX_OUT, 32'h0, "output latch at reset");
    apb(1'b0, 14'h0100, 8'h00, rd, err);
    check("unmapped error", 32'h1, {31'h0, err});
    wr(`GPL_IDX_OUT, 8'h5a);
    rdc(`GPL_IDX_OUT, 32'h5a, "output latch readback");
    $display("test reset done");
  endtask

  // Long and short wake pulses on pin 0, and a non-wake pin moving in halt
  task automatic t_wake;
    int n;
    wr(`GPL_IDX_WAKE_EN, 8'h01);
    wr(`GPL_IDX_PIN_IRQ_EN, 8'h01);
    wr(`GPL_IDX_MASK, 8'h07);
    wr(`GPL_IDX_STAT, 8'h07);
    wr(`GPL_IDX_CAUSE, 8'h03);
    rdc(`GPL_IDX_IN, 32'hfe, "input sample in run");
    enter_halt();
    ext_drv <= 8'h03;
    repeat (5) @(posedge pclk);
    rdc(`GPL_IDX_IN, 32'hfe, "input sample frozen");
    ext_val <= 8'h01;
    wait_halted(1'b0, 100, n);
    check("recovery long enough", 32'h1, {31'h0, n >= 64 && n <= 72});
    rdc(`GPL_IDX_CAUSE, 32'h1, "cause after pin wake");
    rdc(`GPL_IDX_STAT, 32'h5, "status after pin wake");
    rdc(`GPL_IDX_IN, 32'hfd, "input sample after wake");
    check("irq after pin wake", 32'h1, {31'h0, irq});
    wr(`GPL_IDX_STAT, 8'h07);
    wr(`GPL_IDX_CAUSE, 8'h03);
    enter_halt();
    ext_val <= 8'h00;
    repeat (4) @(posedge pclk);
    ext_val <= 8'h01;
    wait_halted(1'b0, 100, n);
    rdc(`GPL_IDX_IN, 32'hfd, "sample after short pulse");
    rdc(`GPL_IDX_STAT, 32'h1, "status after short pulse");
    $display("test wake done");
  endtask

  // Watchdog expiry in halt: interrupt held back until recovery ends
  task automatic t_wdt;
    int n;
    logic seen;
    seen = 1'b0;
    wr(`GPL_IDX_STAT, 8'h07);
    wr(`GPL_IDX_CAUSE, 8'h03);
    wr(`GPL_IDX_CTRL, 8'h01);
    wr(`GPL_IDX_MASK, 8'h02);
    enter_halt();
    wdt_timeout <= 1'b1;
    @(posedge pclk);
    wdt_timeout <= 1'b0;
    for (n = 0; n < 100 && halted !== 1'b0; n++)
    begin
      if (irq !== 1'b0)
        seen = 1'b1;
      @(posedge pclk);
    end
    check("irq quiet in recovery", 32'h0, {31'h0, seen});
    repeat (2) @(posedge pclk);
    check("irq after recovery", 32'h1, {31'h0, irq});
    rdc(`GPL_IDX_CAUSE, 32'h3, "cause after watchdog");
    rdc(`GPL_IDX_STAT, 32'h3, "status after watchdog");
    wr(`GPL_IDX_STAT, 8'h02);
    repeat (2) @(posedge pclk);
    check("irq cleared", 32'h0, {31'h0, irq});
    $display("test watchdog done");
  endtask

  // Latch gating by direction, alternate function and open drain
  task automatic t_out;
    ext_drv <= 8'h00;
    alt_out <= 8'h3c;
    alt_oe  <= 8'h0f;
    wr(`GPL_IDX_DIR, 8'hff);
    wr(`GPL_IDX_ALT, 8'h0f);
    wr(`GPL_IDX_ODRAIN, 8'hf0);
    wr(`GPL_IDX_OUT, 8'ha5);
    repeat (2) @(posedge pclk);
    check("pad oe open drain", 32'h5f, {24'h0, pad.oe});
    check("pad driven bits", 32'h0c, {24'h0, pad.out & pad.oe});
    wr(`GPL_IDX_ODRAIN, 8'h00);
    repeat (2) @(posedge pclk);
    check("pad driven push pull", 32'hac, {24'h0, pad.out & pad.oe});
    wr(`GPL_IDX_DIR, 8'h0f);
    repeat (2) @(posedge pclk);
    check("pad oe inputs", 32'h0f, {24'h0, pad.oe});
    $display("test output done");
  endtask

  // Sink enables and all four drive codes, alternate function fully set
  task automatic t_sink;
    logic [15:0] code;
    logic [7:0]  hi;
    logic [7:0]  lo;
    hi = 8'hcc;
    lo = 8'haa;
    // Pin i expects its high bit over its low bit
    for (int i = 0; i < 8; i++)
      code[2*i +: 2] = {hi[i], lo[i]};
    wr(`GPL_IDX_ALT, 8'hff);
    wr(`GPL_IDX_SINK_EN, 8'h81);
    wr(`GPL_IDX_SINK_HI, 8'hcc);
    wr(`GPL_IDX_SINK_LO, 8'haa);
    repeat (2) @(posedge pclk);
    check("sink enable map", 32'h81, {24'h0, pad.sink_en});
    check("sink codes", {16'h0, code}, {16'h0, pad.sink_code});
    wr(`GPL_IDX_SINK_EN, 8'h00);
    repeat (2) @(posedge pclk);
    check("sink tristate", 32'h0, {24'h0, pad.sink_en});
    $display("test sink done");
  endtask

  initial
  begin
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 16'h0000;
    pwdata      = 32'h00000000;
    alt_out     = 8'h00;
    alt_oe      = 8'h00;
    halt_req    = 1'b0;
    wdt_timeout = 1'b0;
    ext_drv     = 8'h01;
    ext_val     = 8'h00;
    bad_count   = 0;
    n_compared  = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_wake();
    t_wdt();
    t_out();
    t_sink();
    give_verdict();
  end
endmodule
